// >>> bsse_defs.vh
// constants for the branch, skip, shift and bit-I/O execution block
// assumes a decoder in front has already split each instruction into an
// operation code and its operands
//
// Operation
// RL1: compare ops subtract, discard, set ZNVCH, 1 cycle
// RL2: skip if register bit clear, flags kept
// RL3: skip if register bit set, flags kept
// RL4: skip if I/O bit clear, flags kept
// RL5: skip if I/O bit set, flags kept
// RL6: branch if chosen flag set, pc+k+1
// RL7: branch if chosen flag clear, pc+k+1
// RL8: carry set/lower on C=1, clear/higher C=0
// RL9: equal on Z=1, not equal on Z=0
// RL10: minus on N=1, plus on N=0
// RL11: signed ge on N^V=0, lt on 1
// RL12: half carry branches on H flag
// RL13: T flag branches on T flag
// RL14: overflow branches on V flag
// RL15: interrupt branches on I flag
// RL16: I/O bit set/clear, two cycles
// RL17: shift left, zero in, ZCNV, 1 cycle
// RL18: shift right, zero in, ZCNV, 1 cycle
// RL19: rotate left through carry, ZNV, 1 cycle; code also sets C from bit 7
// RL20: skip costs 2, or 3 for two-word
// RL21: shifts set C out, N top, V=N^C
`ifndef BSSE_DEFS_VH
`define BSSE_DEFS_VH

// ----------------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------------
`define BSSE_OP_W 5
`define BSSE_OP_NOP 5'h00
`define BSSE_OP_CMP 5'h01
`define BSSE_OP_CMPC 5'h02
`define BSSE_OP_CMPI 5'h03
`define BSSE_OP_SKRC 5'h04
`define BSSE_OP_SKRS 5'h05
`define BSSE_OP_SKIC 5'h06
`define BSSE_OP_SKIS 5'h07
`define BSSE_OP_BRFS 5'h08
`define BSSE_OP_BRFC 5'h09
`define BSSE_OP_BRANCH_EQUAL_OP 5'h0A
`define BSSE_OP_BRNEQ 5'h0B
`define BSSE_OP_BRCSET 5'h0C
`define BSSE_OP_BRCCLR 5'h0D
`define BSSE_OP_BRSAME 5'h0E
`define BSSE_OP_BRLOW 5'h0F
`define BSSE_OP_BRMIN 5'h10
`define BSSE_OP_BRPLUS 5'h11
`define BSSE_OP_BRSGE 5'h12
`define BSSE_OP_BRSLT 5'h13
`define BSSE_OP_BRHSET 5'h14
`define BSSE_OP_BRHCLR 5'h15
`define BSSE_OP_BRTSET 5'h16
`define BSSE_OP_BRTCLR 5'h17
`define BSSE_OP_BRVSET 5'h18
`define BSSE_OP_BRVCLR 5'h19
`define BSSE_OP_BRIEN 5'h1A
`define BSSE_OP_BRIDIS 5'h1B
`define BSSE_OP_IOSET 5'h1C
`define BSSE_OP_IOCLR 5'h1D
`define BSSE_OP_SHL 5'h1E
`define BSSE_OP_SHR 5'h1F
// rotate shares the shift-left code path, selected by a separate strobe bit
`define BSSE_OP_ROLC 5'h1E

// ----------------------------------------------------------------------
// status flag bit positions
// ----------------------------------------------------------------------
`define BSSE_FLAG_C 0
`define BSSE_FLAG_Z 1
`define BSSE_FLAG_N 2
`define BSSE_FLAG_V 3
`define BSSE_FLAG_S 4
`define BSSE_FLAG_H 5
`define BSSE_FLAG_T 6
`define BSSE_FLAG_I 7

// ----------------------------------------------------------------------
// widths, reset values and cycle counts
// ----------------------------------------------------------------------
`define BSSE_PC_W 10
`define BSSE_PC_RST 10'h000
`define BSSE_FLAGS_RST 8'h00
`define BSSE_CYC_BR_TAKEN 2'h2
`define BSSE_CYC_IO_BIT 2'h2
`define BSSE_CYC_SKIP_1W 2'h2
`define BSSE_CYC_SKIP_2W 2'h3
`define BSSE_CYC_ONE 2'h1

`endif

// >>> bsse_exec.v
// execution unit for compares, skips, flag branches, I/O bit writes and shifts
// assumes one issued operation per opReady pulse, operands valid that cycle, with opCode and bitSel held one cycle more for I/O bit writes,
// and the I/O space answering ioRdData combinationally for ioAddr
`timescale 1ns/1ps
`default_nettype none
`include "bsse_defs.vh"

module bsse_exec (
  input wire clk,
  input wire rst_b,
  input wire opValid,
  input wire [`BSSE_OP_W-1:0] opCode,
  input wire rotSel,
  input wire [7:0] opA,
  input wire [7:0] opB,
  input wire [2:0] bitSel,
  input wire [5:0] ioAddrIn,
  input wire [6:0] brOffset,
  input wire nextTwoWord,
  input wire [7:0] ioRdData,
  output reg opReady,
  output reg [`BSSE_PC_W-1:0] pcOut,
  output reg [7:0] statusFlags,
  output reg [7:0] resultOut,
  output reg resultWe,
  output reg [5:0] ioAddr,
  output reg [7:0] ioWrData,
  output reg ioWe
);

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_IOWR = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [1:0] waitCnt_r;
  reg [1:0] waitCnt_nxt;
  reg [`BSSE_PC_W-1:0] pc_nxt;
  reg [7:0] flags_nxt;
  reg [7:0] res_nxt;
  reg resWe_nxt;
  reg [5:0] ioAddr_nxt;
  reg [7:0] ioWr_nxt;
  reg ioWe_nxt;
  reg ready_nxt;

  wire [7:0] fl;
  assign fl = statusFlags;

  // flag condition for every branch form; generic forms pick by bitSel
  function brCond;
    input [`BSSE_OP_W-1:0] op;
    input [7:0] f;
    input [2:0] s;
    begin
      case (op)
        `BSSE_OP_BRFS: brCond = f[s]; // RL6
        `BSSE_OP_BRFC: brCond = ~f[s]; // RL7
        `BSSE_OP_BRANCH_EQUAL_OP: brCond = f[`BSSE_FLAG_Z]; // RL9
        `BSSE_OP_BRNEQ: brCond = ~f[`BSSE_FLAG_Z]; // RL9
        `BSSE_OP_BRCSET: brCond = f[`BSSE_FLAG_C]; // RL8
        `BSSE_OP_BRLOW: brCond = f[`BSSE_FLAG_C]; // RL8
        `BSSE_OP_BRCCLR: brCond = ~f[`BSSE_FLAG_C]; // RL8
        `BSSE_OP_BRSAME: brCond = ~f[`BSSE_FLAG_C]; // RL8
        `BSSE_OP_BRMIN: brCond = f[`BSSE_FLAG_N]; // RL10
        `BSSE_OP_BRPLUS: brCond = ~f[`BSSE_FLAG_N]; // RL10
        `BSSE_OP_BRSGE: brCond = ~(f[`BSSE_FLAG_N] ^ f[`BSSE_FLAG_V]); // RL11
        `BSSE_OP_BRSLT: brCond = f[`BSSE_FLAG_N] ^ f[`BSSE_FLAG_V]; // RL11
        `BSSE_OP_BRHSET: brCond = f[`BSSE_FLAG_H]; // RL12
        `BSSE_OP_BRHCLR: brCond = ~f[`BSSE_FLAG_H]; // RL12
        `BSSE_OP_BRTSET: brCond = f[`BSSE_FLAG_T]; // RL13
        `BSSE_OP_BRTCLR: brCond = ~f[`BSSE_FLAG_T]; // RL13
        `BSSE_OP_BRVSET: brCond = f[`BSSE_FLAG_V]; // RL14
        `BSSE_OP_BRVCLR: brCond = ~f[`BSSE_FLAG_V]; // RL14
        `BSSE_OP_BRIEN: brCond = f[`BSSE_FLAG_I]; // RL15
        `BSSE_OP_BRIDIS: brCond = ~f[`BSSE_FLAG_I]; // RL15
        default: brCond = 1'b0;
      endcase
    end
  endfunction

  function isBranch;
    input [`BSSE_OP_W-1:0] op;
    begin
      isBranch = (op >= `BSSE_OP_BRFS) && (op <= `BSSE_OP_BRIDIS);
    end
  endfunction

  // ----------------------------------------------------------------------
  // compare datapath
  // ----------------------------------------------------------------------
  wire useCarry;
  wire [7:0] cmpR;
  wire [8:0] cmpDiff;
  wire [4:0] cmpLow;
  wire [7:0] cmpRes;
  wire [7:0] cmpFlags;
  assign useCarry = (opCode == `BSSE_OP_CMPC);
  assign cmpR = opB;
  assign cmpDiff = {1'b0, opA} - {1'b0, cmpR} - {8'h00, useCarry & fl[`BSSE_FLAG_C]}; // RL1
  assign cmpLow = {1'b0, opA[3:0]} - {1'b0, cmpR[3:0]}
    - {4'h0, useCarry & fl[`BSSE_FLAG_C]};
  assign cmpRes = cmpDiff[7:0];

  wire cmpV;
  wire cmpZ;
  assign cmpV = (opA[7] & ~cmpR[7] & ~cmpRes[7]) | (~opA[7] & cmpR[7] & cmpRes[7]);
  // carry form keeps Z only if already set, so multi-byte compares chain
  assign cmpZ = useCarry ? ((cmpRes == 8'h00) & fl[`BSSE_FLAG_Z]) : (cmpRes == 8'h00);
  assign cmpFlags = {fl[7:6], cmpLow[4], cmpRes[7] ^ cmpV, cmpV, cmpRes[7], cmpZ,
    cmpDiff[8]}; // RL1

  // ----------------------------------------------------------------------
  // shift and rotate datapath
  // ----------------------------------------------------------------------
  reg [7:0] shRes;
  reg shC;
  wire [7:0] shFlags;
  wire shN;
  wire shV;
  always @* begin
    if (opCode == `BSSE_OP_SHR) begin
      shRes = {1'b0, opA[7:1]}; // RL18
      shC = opA[0];
    end else if (rotSel) begin
      shRes = {opA[6:0], fl[`BSSE_FLAG_C]}; // RL19
      shC = opA[7];
    end else begin
      shRes = {opA[6:0], 1'b0}; // RL17
      shC = opA[7];
    end
  end
  assign shN = shRes[7]; // RL21
  assign shV = shN ^ shC; // RL21
  assign shFlags = {fl[7:5], shN ^ shV, shV, shN, shRes == 8'h00, shC};

  // ----------------------------------------------------------------------
  // skip test: register bit or I/O bit
  // ----------------------------------------------------------------------
  wire regBit;
  wire ioBit;
  assign regBit = opA[bitSel];
  assign ioBit = ioRdData[bitSel];

  wire [`BSSE_PC_W-1:0] pcInc;
  wire [`BSSE_PC_W-1:0] pcBr;
  assign pcInc = pcOut + 10'h001;
  // offset is sign-extended before the add so backward branches wrap cleanly
  assign pcBr = pcOut + {{3{brOffset[6]}}, brOffset} + 10'h001; // RL6

  // ----------------------------------------------------------------------
  // next-state decode
  // ----------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    waitCnt_nxt = waitCnt_r;
    pc_nxt = pcOut;
    flags_nxt = statusFlags;
    res_nxt = resultOut;
    resWe_nxt = 1'b0;
    ioAddr_nxt = ioAddr;
    ioWr_nxt = ioWrData;
    ioWe_nxt = 1'b0;
    ready_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (opValid) begin
          ready_nxt = 1'b1;
          pc_nxt = pcInc;
          case (opCode)
            `BSSE_OP_CMP, `BSSE_OP_CMPC, `BSSE_OP_CMPI: begin
              flags_nxt = cmpFlags; // RL1
            end
            `BSSE_OP_SKRC, `BSSE_OP_SKRS, `BSSE_OP_SKIC, `BSSE_OP_SKIS: begin
              if ((opCode == `BSSE_OP_SKRC && !regBit) || // RL2
                  (opCode == `BSSE_OP_SKRS && regBit) || // RL3
                  (opCode == `BSSE_OP_SKIC && !ioBit) || // RL4
                  (opCode == `BSSE_OP_SKIS && ioBit)) begin // RL5
                pc_nxt = nextTwoWord ? pcOut + 10'h003 : pcOut + 10'h002;
                ready_nxt = 1'b0;
                state_nxt = ST_WAIT;
                // RL20
                waitCnt_nxt = nextTwoWord ? `BSSE_CYC_SKIP_2W - 2'h1 : `BSSE_CYC_SKIP_1W - 2'h1;
              end
            end
            `BSSE_OP_IOSET, `BSSE_OP_IOCLR: begin
              ioAddr_nxt = ioAddrIn;
              ready_nxt = 1'b0;
              state_nxt = ST_IOWR; // RL16
            end
            `BSSE_OP_SHL, `BSSE_OP_SHR: begin
              res_nxt = shRes;
              resWe_nxt = 1'b1;
              flags_nxt = shFlags; // RL17
            end
            default: begin
              if (isBranch(opCode) && brCond(opCode, statusFlags, bitSel)) begin
                pc_nxt = pcBr;
                ready_nxt = 1'b0;
                state_nxt = ST_WAIT;
                waitCnt_nxt = `BSSE_CYC_BR_TAKEN - 2'h1;
              end
            end
          endcase
        end
      end
      ST_WAIT: begin
        waitCnt_nxt = waitCnt_r - 2'h1;
        if (waitCnt_r == 2'h1) begin
          ready_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_IOWR: begin
        // read-modify-write in the second cycle; only the chosen bit changes
        ioWr_nxt = ioRdData;
        ioWr_nxt[bitSel] = (opCode == `BSSE_OP_IOSET); // RL16
        ioWe_nxt = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      waitCnt_r <= 2'h0;
      pcOut <= `BSSE_PC_RST;
      statusFlags <= `BSSE_FLAGS_RST;
      resultOut <= 8'h00;
      resultWe <= 1'b0;
      ioAddr <= 6'h00;
      ioWrData <= 8'h00;
      ioWe <= 1'b0;
      opReady <= 1'b0;
    end else begin
      state_r <= state_nxt;
      waitCnt_r <= waitCnt_nxt;
      pcOut <= pc_nxt;
      statusFlags <= flags_nxt;
      resultOut <= res_nxt;
      resultWe <= resWe_nxt;
      ioAddr <= ioAddr_nxt;
      ioWrData <= ioWr_nxt;
      ioWe <= ioWe_nxt;
      opReady <= ready_nxt;
    end
  end

endmodule // bsse_exec
`default_nettype wire

// >>> bsse_exec_chk.sv
// checker for bsse_exec: timing and data relations seen at its ports
// assumes operations are issued only while the block is idle
`timescale 1ns/1ps
`default_nettype none
`include "bsse_defs.vh"
module bsse_exec_chk (
  input wire clk,
  input wire rst_b,
  input wire opValid,
  input wire [`BSSE_OP_W-1:0] opCode,
  input wire rotSel,
  input wire [7:0] opA,
  input wire [7:0] opB,
  input wire [2:0] bitSel,
  input wire [5:0] ioAddrIn,
  input wire [6:0] brOffset,
  input wire nextTwoWord,
  input wire [7:0] ioRdData,
  input wire opReady,
  input wire [`BSSE_PC_W-1:0] pcOut,
  input wire [7:0] statusFlags,
  input wire [7:0] resultOut,
  input wire resultWe,
  input wire [5:0] ioAddr,
  input wire [7:0] ioWrData,
  input wire ioWe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence waitTwo; !opReady ##1 opReady; endsequence
  sequence waitThree; !opReady [*2] ##1 opReady; endsequence
  AST_CMP_ONE: assert property (opValid && opCode == `BSSE_OP_CMPI |=> opReady
    && statusFlags[1] == ($past(opA) == $past(opB)) && statusFlags[0] == ($past(opA) < $past(opB)))
    else $error("compare flags or timing wrong");
  AST_SHR: assert property (opValid && opCode == `BSSE_OP_SHR |=> opReady && resultWe
    && resultOut == {1'b0, $past(opA[7:1])} && statusFlags[0] == $past(opA[0]))
    else $error("right shift wrong");
  AST_SHL: assert property (opValid && opCode == `BSSE_OP_SHL && !rotSel |=> resultWe
    && resultOut == {$past(opA[6:0]), 1'b0} && statusFlags[3] == (statusFlags[2] ^ statusFlags[0]))
    else $error("left shift wrong");
  AST_ROL: assert property (opValid && opCode == `BSSE_OP_SHL && rotSel |=>
    resultOut == {$past(opA[6:0]), $past(statusFlags[0])} && statusFlags[0] == $past(opA[7]))
    else $error("rotate wrong");
  AST_IO_SET: assert property (opValid && opCode == `BSSE_OP_IOSET |=> !opReady ##1
    (opReady && ioWe && ioWrData[$past(bitSel, 2)] && ioAddr == $past(ioAddrIn, 2)))
    else $error("io bit set wrong");
  AST_IO_CLR: assert property (opValid && opCode == `BSSE_OP_IOCLR |=> !ioWe ##1
    (ioWe && !ioWrData[$past(bitSel, 2)])) else $error("io bit clear wrong");
  AST_SKIP_FLAGS: assert property (opValid && opCode[4:2] == 3'b001 |=> $stable(statusFlags))
    else $error("skip changed flags");
  AST_SKIP_TWO: assert property (opValid && opCode == `BSSE_OP_SKRS && opA[bitSel] && nextTwoWord
    |=> pcOut == $past(pcOut) + 10'h003 ##0 waitThree) else $error("two word skip wrong");
  AST_BR_TAKEN: assert property (opValid && opCode == `BSSE_OP_BRFS && statusFlags[bitSel] |=>
    pcOut == $past(pcOut) + {{3{$past(brOffset[6])}}, $past(brOffset)} + 10'h001 ##0 waitTwo)
    else $error("taken branch wrong");
  AST_SGE_NOT: assert property (opValid && opCode == `BSSE_OP_BRSGE && (statusFlags[2] ^ statusFlags[3])
    |=> opReady && pcOut == $past(pcOut) + 10'h001) else $error("untaken branch wrong");
endmodule // bsse_exec_chk
bind bsse_exec bsse_exec_chk i_bsse_exec_chk (.clk(clk), .rst_b(rst_b), .opValid(opValid),
  .opCode(opCode), .rotSel(rotSel), .opA(opA), .opB(opB), .bitSel(bitSel), .ioAddrIn(ioAddrIn),
  .brOffset(brOffset), .nextTwoWord(nextTwoWord), .ioRdData(ioRdData), .opReady(opReady),
  .pcOut(pcOut), .statusFlags(statusFlags), .resultOut(resultOut), .resultWe(resultWe),
  .ioAddr(ioAddr), .ioWrData(ioWrData), .ioWe(ioWe));
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for bsse_exec: corner and random operations
// assumes a reference of pc, flags and cycle counts kept in the bench
`timescale 1ns/1ps
`default_nettype none
`include "bsse_defs.vh"
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin failures++; \
  $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic opValid = 1'b0;
  logic [`BSSE_OP_W-1:0] opCode = 5'h00;
  logic rotSel = 1'b0;
  logic [7:0] opA = 8'h00, opB = 8'h00, ioRdData = 8'h00, fE = 8'h00, rE;
  logic [2:0] bitSel = 3'h0, cycE;
  logic [5:0] ioAddrIn = 6'h00;
  logic [6:0] brOffset = 7'h00;
  logic nextTwoWord = 1'b0;
  logic [9:0] pcE = 10'h000;
  logic [63:0] r;
  wire logic opReady, resultWe, ioWe;
  wire logic [9:0] pcOut;
  wire logic [7:0] statusFlags, resultOut, ioWrData;
  wire logic [5:0] ioAddr;
  integer failures = 0, checkCount = 0, cycles = 0, seed = 32'h111EEB41;
  always #25 clk = ~clk;
  bsse_exec i_bsse_exec (.clk(clk), .rst_b(rst_b), .opValid(opValid), .opCode(opCode),
    .rotSel(rotSel), .opA(opA), .opB(opB), .bitSel(bitSel), .ioAddrIn(ioAddrIn),
    .brOffset(brOffset), .nextTwoWord(nextTwoWord), .ioRdData(ioRdData), .opReady(opReady),
    .pcOut(pcOut), .statusFlags(statusFlags), .resultOut(resultOut), .resultWe(resultWe),
    .ioAddr(ioAddr), .ioWrData(ioWrData), .ioWe(ioWe));
  // clear forms sit on odd codes except the same-or-higher and signed pairs
  function automatic logic brTake(input logic [4:0] op, input logic [7:0] f, input logic [2:0] s);
    logic v;
    case (op[4:1])
      4'h4: v = f[s];
      4'h5: v = f[1];
      4'h6, 4'h7: v = f[0];
      4'h8: v = f[2];
      4'h9: v = f[2] ^ f[3];
      4'hA: v = f[5];
      4'hB: v = f[6];
      4'hC: v = f[3];
      default: v = f[7];
    endcase
    return v ^ op[0] ^ (op[4:1] == 4'h7 || op[4:1] == 4'h9);
  endfunction
  task automatic exec(input logic [4:0] op, input logic rot, input logic [7:0] a, input logic [7:0] b,
    input logic [2:0] bs, input logic [5:0] ad, input logic [6:0] k, input logic tw,
    input logic [7:0] io);
    logic [8:0] d;
    logic v;
    logic [2:0] n;
    cycE = 3'h1;
    rE = io;
    d = {1'b0, a} - {1'b0, b} - ((op == `BSSE_OP_CMPC) ? fE[0] : 1'b0);
    v = brTake(op, fE, bs);
    if (op[4:2] == 3'b001 && (op[1] ? io[bs] : a[bs]) == op[0]) begin
      cycE = tw ? 3'h3 : 3'h2;
      pcE = pcE + (tw ? 10'h003 : 10'h002);
    end else if (op >= `BSSE_OP_BRFS && op <= `BSSE_OP_BRIDIS && v) begin
      cycE = 3'h2;
      pcE = pcE + {{3{k[6]}}, k} + 10'h001;
    end else pcE = pcE + 10'h001;
    if (op >= `BSSE_OP_CMP && op <= `BSSE_OP_CMPI) begin
      fE[0] = d[8];
      fE[1] = (d[7:0] == 8'h00) && (op != `BSSE_OP_CMPC || fE[1]);
      fE[2] = d[7];
      fE[3] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
      fE[5] = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
      fE[4] = fE[2] ^ fE[3];
    end
    if (op == `BSSE_OP_IOSET || op == `BSSE_OP_IOCLR) begin
      cycE = 3'h2;
      rE[bs] = (op == `BSSE_OP_IOSET);
    end
    if (op == `BSSE_OP_SHL || op == `BSSE_OP_SHR) begin
      rE = (op == `BSSE_OP_SHR) ? {1'b0, a[7:1]} : {a[6:0], rot & fE[0]};
      fE[0] = (op == `BSSE_OP_SHR) ? a[0] : a[7];
      fE[1] = (rE == 8'h00);
      fE[2] = rE[7];
      fE[3] = rE[7] ^ fE[0];
      fE[4] = fE[2] ^ fE[3];
    end
    @(posedge clk);
    opValid <= 1'b1;
    {opCode, rotSel, opA, opB, bitSel, ioAddrIn, brOffset, nextTwoWord, ioRdData} <=
      {op, rot, a, b, bs, ad, k, tw, io};
    n = 3'h0;
    // the one-cycle ready pulse follows the issue edge, so look from that edge on
    do begin
      @(posedge clk);
      if (n == 3'h0) opValid <= 1'b0;
      #1;
      n++;
    end while (opReady !== 1'b1 && n < 3'h5);
    `CHK(n, cycE)
    `CHK(pcOut, pcE)
    `CHK(statusFlags, fE)
    if (op == `BSSE_OP_SHL || op == `BSSE_OP_SHR) `CHK({resultWe, resultOut}, {1'b1, rE})
    if (cycE == 3'h2 && op[4:1] == 4'hE) `CHK({ioWe, ioAddr, ioWrData}, {1'b1, ad, rE})
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    exec(`BSSE_OP_CMPI, 1'b0, 8'h80, 8'h80, 3'h0, 6'h00, 7'h00, 1'b0, 8'h00);
    exec(`BSSE_OP_BRANCH_EQUAL_OP, 1'b0, 8'h00, 8'h00, 3'h0, 6'h00, 7'h40, 1'b0, 8'h00);
    exec(`BSSE_OP_CMP, 1'b0, 8'h00, 8'h01, 3'h0, 6'h00, 7'h00, 1'b0, 8'h00);
    exec(`BSSE_OP_CMPC, 1'b0, 8'h01, 8'h00, 3'h0, 6'h00, 7'h00, 1'b0, 8'h00);
    exec(`BSSE_OP_SHL, 1'b0, 8'h80, 8'h00, 3'h0, 6'h00, 7'h00, 1'b0, 8'h00);
    exec(`BSSE_OP_SHL, 1'b1, 8'h81, 8'h00, 3'h0, 6'h00, 7'h00, 1'b0, 8'h00);
    exec(`BSSE_OP_SKRS, 1'b0, 8'hFF, 8'h00, 3'h7, 6'h00, 7'h00, 1'b1, 8'h00);
    exec(`BSSE_OP_SKIC, 1'b0, 8'h00, 8'h00, 3'h0, 6'h00, 7'h00, 1'b0, 8'hFE);
    exec(`BSSE_OP_IOSET, 1'b0, 8'h00, 8'h00, 3'h7, 6'h3F, 7'h00, 1'b0, 8'h00);
    exec(`BSSE_OP_IOCLR, 1'b0, 8'h00, 8'h00, 3'h0, 6'h01, 7'h00, 1'b0, 8'hFF);
    repeat (400) begin
      r = {$random(seed), $random(seed)};
      exec((r[4:0] == 5'h00) ? `BSSE_OP_CMP : r[4:0], r[5], r[31:24], r[39:32], r[8:6],
        r[14:9], r[21:15], r[22], r[47:40]);
    end
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
